// >>> core/serial_uart_data_port.sv
/*
  serial-port uart: fifo and top module.
  assumes pins arrive asynchronous to clk; sclk far slower than clk.
*/
// Summary of operation
// RULE_01: command 01 returns stored configuration
// RULE_02: extra_end_bit sends two stop bits
// RULE_03: parity_on adds parity on both directions
// RULE_04: word_size picks seven or eight bits
// RULE_05: readback bit0 drives baud clock on rts
// RULE_06: command 10 transmits tx_byte, bit7 masked
// RULE_07: send_inhibit only updates the rts pin
// RULE_08: parity_out_value sent only with parity
// RULE_09: response bit9 is inverted cts pin
// RULE_10: response bit8 is received parity
// RULE_11: response low byte is rx_byte
// RULE_12: bit15 shows data waiting or reading
// RULE_13: bit14 shows transmit buffer empty
// RULE_14: bit10 frame error or line activity
// RULE_15: bit15 at cs fall, shift on falls
// RULE_16: baud generator gives sixteen times clock
// RULE_17: rate_select maps to divisor table
// RULE_18: data access releases cleared interrupt
// RULE_19: eight word receive fifo
// RULE_20: entering shutdown empties the fifo
// RULE_21: fifo_disable turns receive fifo off
// RULE_22: command 11 writes configuration fields
// RULE_23: irq held while data waits and masked in
// RULE_24: frame error set, cleared on good frame
// RULE_25: data access clears transmit empty source
// RULE_26: sixteen sclk cycles, sample on rise
// RULE_27: data access pops the oldest entry
`timescale 1ns/1ps

module sync_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  logic             push;
  logic             pop;

  assign in_ready  = (count_ff != (AW+1)'(DEPTH));
  assign out_valid = (count_ff != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr_ff];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || flush) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      count_ff <= count_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

module serial_uart_data_port (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic osc_input,
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic din,
  output logic      dout,
  output logic      dout_oe,
  output logic      irq_n,
  input  wire logic rx,
  output logic      tx,
  input  wire logic cts_n,
  output logic      rts_n
);
  import uart_pkg::*;

  logic [5:0]       sy1_ff;
  logic [5:0]       sy2_ff;
  logic [5:0]       sy3_ff;
  logic [5:0]       pin_ff;
  logic [5:0]       pin_prev_ff;
  logic [5:0]       rise;
  logic [5:0]       fall;
  logic             cs_low;
  logic             sclk_rise;
  logic             sclk_fall;
  logic [4:0]       bit_cnt_ff;
  logic [15:0]      in_sr_ff;
  logic [15:0]      out_sr_ff;
  logic [1:0]       cmd_ff;
  logic [15:0]      word;
  logic             word_done;
  logic             data_access;
  logic [13:0]      payload;
  cfg_t             cfg_ff;
  logic             test_ff;
  logic             rts_ff;
  logic             rts_n_ff;
  logic             sleep_state_ff;
  logic             entering_sleep;
  logic             flag_ff;
  logic             reading_ff;
  logic             data_avail;
  logic             tx_empty_src_ff;
  logic             tx_buf_valid_ff;
  logic             tx_buf_prev_ff;
  rx_entry_t        tx_buf_ff;
  logic [8:0]       div_cnt_ff;
  logic [8:0]       divider;
  logic             tick;
  logic             clk16;
  line_state_t      tx_state_ff;
  logic [3:0]       tx_tick_ff;
  logic [3:0]       tx_idx_ff;
  logic [8:0]       tx_sr_ff;
  logic             tx_line_ff;
  logic             tx_second_ff;
  logic             tx_take;
  line_state_t      rx_state_ff;
  logic [3:0]       rx_tick_ff;
  logic [3:0]       rx_idx_ff;
  logic [8:0]       rx_sr_ff;
  logic             rx_push;
  logic             rx_good;
  rx_entry_t        rx_entry;
  rx_entry_t        head;
  logic [ENTRY_W-1:0] head_raw;
  logic             fifo_in_ready;
  logic             fifo_out_valid;
  logic             fifo_flush;
  logic             fifo_pop;
  logic [8:0]       rx_aligned;

  // pin sampling: a change counts once stages two and three agree
  always_ff @(posedge clk) begin
    if (reset) begin
      sy1_ff      <= PIN_IDLE;
      sy2_ff      <= PIN_IDLE;
      sy3_ff      <= PIN_IDLE;
      pin_ff      <= PIN_IDLE;
      pin_prev_ff <= PIN_IDLE;
    end else begin
      sy1_ff      <= {osc_input, cts_n, rx, din, cs_n, sclk};
      sy2_ff      <= sy1_ff;
      sy3_ff      <= sy2_ff;
      pin_ff      <= (~(sy2_ff ^ sy3_ff) & sy3_ff)
                   | ((sy2_ff ^ sy3_ff) & pin_ff);
      pin_prev_ff <= pin_ff;
    end
  end

  assign rise      = pin_ff & ~pin_prev_ff;
  assign fall      = ~pin_ff & pin_prev_ff;
  assign cs_low    = !pin_ff[PIN_CS];
  assign sclk_rise = rise[PIN_SCLK] && cs_low;
  assign sclk_fall = fall[PIN_SCLK] && cs_low;
  assign word      = {in_sr_ff[14:0], pin_ff[PIN_DIN]};
  assign word_done = sclk_rise && (bit_cnt_ff == 5'(XFER_LAST)); // RULE_26
  assign data_access = word_done && !word[CMD_LO];

  assign head       = rx_entry_t'(head_raw);
  assign data_avail = fifo_out_valid || reading_ff; // RULE_12

  // response low bits chosen once the command bits are in
  always_comb begin
    payload = '0;
    unique case ({in_sr_ff[0], pin_ff[PIN_DIN]})
      CMD_RD_CFG: begin
        payload = cfg_ff; // RULE_01
        payload[12] = sleep_state_ff; // RULE_21
      end
      CMD_WR_DATA, CMD_RD_DATA: begin
        payload[10] = flag_ff; // RULE_14
        payload[9]  = !pin_ff[PIN_CTS]; // RULE_09
        payload[8]  = fifo_out_valid && head.parity; // RULE_10
        payload[7:0] = fifo_out_valid ? head.data : 8'h00; // RULE_11
        if (cfg_ff.word_size) begin
          payload[7] = 1'b0; // RULE_11
        end
      end
      CMD_WR_CFG: payload = '0;
    endcase
  end

  // serial port shift logic
  always_ff @(posedge clk) begin
    if (reset) begin
      bit_cnt_ff <= '0;
      in_sr_ff   <= '0;
      out_sr_ff  <= '0;
      cmd_ff     <= CMD_RD_DATA;
    end else if (!cs_low) begin
      bit_cnt_ff <= '0;
    end else if (fall[PIN_CS]) begin
      bit_cnt_ff <= '0;
      out_sr_ff  <= {data_avail, !tx_buf_valid_ff, 14'h0000}; // RULE_15
    end else if (sclk_rise) begin
      bit_cnt_ff <= bit_cnt_ff + 5'h01;
      in_sr_ff   <= word; // RULE_26
      if (bit_cnt_ff == 5'h01) begin
        cmd_ff           <= {in_sr_ff[0], pin_ff[PIN_DIN]};
        out_sr_ff[14:1]  <= payload;
      end
    end else if (sclk_fall) begin
      out_sr_ff <= {out_sr_ff[14:0], 1'b0}; // RULE_15
    end
  end

  assign dout    = out_sr_ff[15];
  assign dout_oe = cs_low;

  // configuration, test mode and rts state
  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_ff  <= cfg_t'(CFG_RESET); // RULE_21
      test_ff <= 1'b0;
      rts_ff  <= 1'b0;
    end else if (word_done) begin
      test_ff <= (word[CMD_HI:CMD_LO] == CMD_RD_CFG) && word[CFG_TEST]; // RULE_05
      if (word[CMD_HI:CMD_LO] == CMD_WR_CFG) begin
        cfg_ff <= cfg_t'(word[13:0]); // RULE_22
      end
      if (word[CMD_HI:CMD_LO] == CMD_WR_DATA) begin
        rts_ff <= word[WD_RTS]; // RULE_07
      end
    end
  end

  // while cs is low, test mode puts the 16x clock on rts and holds tx low
  always_ff @(posedge clk) begin
    if (reset) begin
      rts_n_ff <= 1'b1;
    end else begin
      rts_n_ff <= (test_ff && cs_low) ? clk16 : !rts_ff; // RULE_05
    end
  end
  assign rts_n = rts_n_ff;
  assign tx    = (test_ff && cs_low) ? 1'b0 : tx_line_ff;

  // baud generator counting oscillator edges
  assign divider = rate_divider(cfg_ff.rate_select); // RULE_17
  assign tick    = rise[PIN_OSC] && (div_cnt_ff == divider - 9'h001)
                   && !sleep_state_ff; // RULE_16
  assign clk16   = (divider == 9'h001) ? pin_ff[PIN_OSC]
                 : (div_cnt_ff < (divider >> 1));

  always_ff @(posedge clk) begin
    if (reset) begin
      div_cnt_ff <= '0;
    end else if (rise[PIN_OSC]) begin
      div_cnt_ff <= (div_cnt_ff >= divider - 9'h001) ? 9'h000
                  : div_cnt_ff + 9'h001; // RULE_16
    end
  end

  // software shutdown once transmit side has drained
  assign entering_sleep = cfg_ff.sleep_request && !sleep_state_ff
                       && (tx_state_ff == LN_IDLE) && !tx_buf_valid_ff;
  always_ff @(posedge clk) begin
    if (reset) begin
      sleep_state_ff <= 1'b0;
    end else if (!cfg_ff.sleep_request) begin
      sleep_state_ff <= 1'b0;
    end else if (entering_sleep) begin
      sleep_state_ff <= 1'b1;
    end
  end

  // transmit buffer: loaded by write data, taken by the transmitter
  assign tx_take = (tx_state_ff == LN_IDLE) && tx_buf_valid_ff
                && !sleep_state_ff;
  always_ff @(posedge clk) begin
    if (reset) begin
      tx_buf_valid_ff <= 1'b0;
      tx_buf_ff       <= '0;
    end else if (word_done && word[CMD_HI:CMD_LO] == CMD_WR_CFG) begin
      tx_buf_valid_ff <= 1'b0;
    end else if (word_done && word[CMD_HI:CMD_LO] == CMD_WR_DATA
                 && !word[WD_INHIBIT]) begin // RULE_07
      tx_buf_valid_ff <= 1'b1; // RULE_06
      tx_buf_ff.parity <= word[WD_PARITY];
      tx_buf_ff.data   <= {word[WD_BYTE7] && !cfg_ff.word_size,
                           word[6:0]}; // RULE_06
    end else if (tx_take) begin
      tx_buf_valid_ff <= 1'b0; // RULE_13
    end
  end

  // transmitter: start, data, optional parity, one or two stops
  always_ff @(posedge clk) begin
    if (reset) begin
      tx_state_ff  <= LN_IDLE;
      tx_tick_ff   <= '0;
      tx_idx_ff    <= '0;
      tx_sr_ff     <= '0;
      tx_line_ff   <= 1'b1;
      tx_second_ff <= 1'b0;
    end else begin
      unique case (tx_state_ff)
        LN_IDLE: begin
          tx_line_ff <= 1'b1;
          if (tx_take) begin
            tx_sr_ff    <= cfg_ff.word_size
                         ? {1'b0, tx_buf_ff.parity, tx_buf_ff.data[6:0]}
                         : tx_buf_ff; // RULE_08
            tx_line_ff  <= 1'b0;
            tx_tick_ff  <= '0;
            tx_state_ff <= LN_START;
          end
        end
        LN_START: if (tick) begin
          tx_tick_ff <= tx_tick_ff + 4'h1;
          if (tx_tick_ff == OVS_LAST) begin
            tx_line_ff  <= tx_sr_ff[0];
            tx_sr_ff    <= {1'b0, tx_sr_ff[8:1]};
            tx_idx_ff   <= '0;
            tx_state_ff <= LN_BITS;
          end
        end
        LN_BITS: if (tick) begin
          tx_tick_ff <= tx_tick_ff + 4'h1;
          if (tx_tick_ff == OVS_LAST) begin
            tx_idx_ff <= tx_idx_ff + 4'h1;
            if (tx_idx_ff == frame_bits(cfg_ff) - 4'h1) begin // RULE_03 RULE_04
              tx_line_ff   <= 1'b1;
              tx_second_ff <= 1'b0;
              tx_state_ff  <= LN_STOP;
            end else begin
              tx_line_ff <= tx_sr_ff[0];
              tx_sr_ff   <= {1'b0, tx_sr_ff[8:1]};
            end
          end
        end
        LN_STOP: if (tick) begin
          tx_tick_ff <= tx_tick_ff + 4'h1;
          if (tx_tick_ff == OVS_LAST) begin
            if (cfg_ff.extra_end_bit && !tx_second_ff) begin
              tx_second_ff <= 1'b1; // RULE_02
            end else begin
              tx_state_ff <= LN_IDLE;
            end
          end
        end
      endcase
    end
  end

  // receiver: mid-bit sampling on the 16x tick
  assign rx_aligned = rx_sr_ff >> (4'h9 - frame_bits(cfg_ff));
  always_comb begin
    rx_entry.data   = cfg_ff.word_size ? {1'b0, rx_aligned[6:0]}
                                       : rx_aligned[7:0]; // RULE_04
    rx_entry.parity = cfg_ff.parity_on
                    && rx_aligned[frame_bits(cfg_ff) - 4'h1]; // RULE_03
  end
  assign rx_good = (rx_state_ff == LN_STOP) && tick
                && (rx_tick_ff == OVS_LAST) && pin_ff[PIN_RX];
  assign rx_push = rx_good && (!cfg_ff.fifo_disable || !fifo_out_valid); // RULE_21

  always_ff @(posedge clk) begin
    if (reset || sleep_state_ff) begin
      rx_state_ff <= LN_IDLE;
      rx_tick_ff  <= '0;
      rx_idx_ff   <= '0;
      rx_sr_ff    <= '0;
    end else begin
      unique case (rx_state_ff)
        LN_IDLE: if (tick && !pin_ff[PIN_RX]) begin
          rx_tick_ff  <= '0;
          rx_state_ff <= LN_START;
        end
        LN_START: if (tick) begin
          rx_tick_ff <= rx_tick_ff + 4'h1;
          if (rx_tick_ff == HALF_BIT) begin
            rx_tick_ff  <= '0;
            rx_idx_ff   <= '0;
            rx_state_ff <= pin_ff[PIN_RX] ? LN_IDLE : LN_BITS;
          end
        end
        LN_BITS: if (tick) begin
          rx_tick_ff <= rx_tick_ff + 4'h1;
          if (rx_tick_ff == OVS_LAST) begin
            rx_sr_ff  <= {pin_ff[PIN_RX], rx_sr_ff[8:1]};
            rx_idx_ff <= rx_idx_ff + 4'h1;
            if (rx_idx_ff == frame_bits(cfg_ff) - 4'h1) begin
              rx_state_ff <= LN_STOP;
            end
          end
        end
        LN_STOP: if (tick) begin
          rx_tick_ff <= rx_tick_ff + 4'h1;
          if (rx_tick_ff == OVS_LAST) begin
            rx_state_ff <= LN_IDLE;
          end
        end
      endcase
    end
  end

  // frame error in normal mode, line activity while asleep; events win
  always_ff @(posedge clk) begin
    if (reset || entering_sleep
        || (!cfg_ff.sleep_request && sleep_state_ff)) begin
      flag_ff <= 1'b0;
    end else if (sleep_state_ff && (rise[PIN_RX] || fall[PIN_RX])) begin
      flag_ff <= 1'b1; // RULE_14
    end else if (!sleep_state_ff && (rx_state_ff == LN_STOP) && tick
                 && (rx_tick_ff == OVS_LAST)) begin
      flag_ff <= !pin_ff[PIN_RX]; // RULE_24
    end else if (word_done && word[CMD_HI:CMD_LO] == CMD_WR_CFG) begin
      flag_ff <= 1'b0;
    end
  end

  assign fifo_flush = entering_sleep // RULE_20
                   || (word_done && word[CMD_HI:CMD_LO] == CMD_WR_CFG);
  assign fifo_pop   = data_access && fifo_out_valid; // RULE_27

  sync_fifo #(
    .WIDTH (ENTRY_W),
    .DEPTH (FIFO_DEPTH)
  ) rx_fifo ( // RULE_19
    .clk       (clk),
    .reset     (reset),
    .flush     (fifo_flush),
    .in_valid  (rx_push),
    .in_ready  (fifo_in_ready),
    .in_data   (rx_entry),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (head_raw)
  );

  // read in progress keeps data_avail up until cs rises
  always_ff @(posedge clk) begin
    if (reset || rise[PIN_CS] || fifo_flush) begin
      reading_ff <= 1'b0;
    end else if (fifo_pop) begin
      reading_ff <= 1'b1; // RULE_12
    end
  end

  // transmit-empty source: set wins over the data access clear
  always_ff @(posedge clk) begin
    if (reset) begin
      tx_buf_prev_ff  <= 1'b0;
      tx_empty_src_ff <= 1'b0;
    end else begin
      tx_buf_prev_ff <= tx_buf_valid_ff;
      if (tx_buf_prev_ff && !tx_buf_valid_ff) begin
        tx_empty_src_ff <= 1'b1;
      end else if (data_access) begin
        tx_empty_src_ff <= 1'b0; // RULE_25
      end
    end
  end

  // data, parity and flag levels plus the held transmit-empty source, which data access clears
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= !((cfg_ff.rx_avail_mask && data_avail) // RULE_23
              || (cfg_ff.tx_empty_mask && tx_empty_src_ff) // RULE_18
              || (cfg_ff.parity_mask && fifo_out_valid && head.parity)
              || (cfg_ff.flag_mask && flag_ff));
    end
  end

  logic unused_ok;
  assign unused_ok = fifo_in_ready & cfg_ff.irda & cmd_ff[0];
endmodule

// >>> core/uart_pkg.sv
/*
  constants, field layouts, types and helpers for the serial-port uart.
  assumes a single 50 MHz clock domain; all pins are sampled into it.
*/
package uart_pkg;
  localparam int          XFER_LAST   = 15;
  localparam logic [1:0]  CMD_WR_CFG  = 2'h3;
  localparam logic [1:0]  CMD_RD_CFG  = 2'h1;
  localparam logic [1:0]  CMD_WR_DATA = 2'h2;
  localparam logic [1:0]  CMD_RD_DATA = 2'h0;
  localparam int          CMD_HI      = 15;
  localparam int          CMD_LO      = 14;
  localparam int          CFG_TEST    = 0;
  localparam int          WD_INHIBIT  = 10;
  localparam int          WD_RTS      = 9;
  localparam int          WD_PARITY   = 8;
  localparam int          WD_BYTE7    = 7;
  localparam int          RSP_AVAIL   = 15;
  localparam int          RSP_VACANT  = 14;
  localparam int          PIN_SCLK    = 0;
  localparam int          PIN_CS      = 1;
  localparam int          PIN_DIN     = 2;
  localparam int          PIN_RX      = 3;
  localparam int          PIN_CTS     = 4;
  localparam int          PIN_OSC     = 5;
  localparam logic [5:0]  PIN_IDLE    = 6'h1a;
  localparam logic [3:0]  OVS_LAST    = 4'hf;
  localparam logic [3:0]  HALF_BIT    = 4'h7;
  localparam int          FIFO_DEPTH  = 8;
  localparam int          ENTRY_W     = 9;
  localparam logic [13:0] CFG_RESET   = 14'h0000;

  typedef struct packed {
    logic       parity;
    logic [7:0] data;
  } rx_entry_t;

  typedef struct packed {
    logic       fifo_disable;
    logic       sleep_request;
    logic       tx_empty_mask;
    logic       rx_avail_mask;
    logic       parity_mask;
    logic       flag_mask;
    logic       irda;
    logic       extra_end_bit;
    logic       parity_on;
    logic       word_size;
    logic [3:0] rate_select;
  } cfg_t;

  typedef enum logic [3:0] {
    LN_IDLE  = 4'h1,
    LN_START = 4'h2,
    LN_BITS  = 4'h4,
    LN_STOP  = 4'h8
  } line_state_t;

  // low codes are powers of two, high codes three times those
  function automatic logic [8:0] rate_divider(input logic [3:0] sel);
    rate_divider = sel[3] ? (9'h003 << sel[2:0]) : (9'h001 << sel[2:0]);
  endfunction

  // data bits plus optional parity bit
  function automatic logic [3:0] frame_bits(input cfg_t c);
    frame_bits = (c.word_size ? 4'h7 : 4'h8) + {3'h0, c.parity_on};
  endfunction
endpackage

// >>> test/serial_uart_data_port_sva.sv
/*
  checker for the serial-port uart: port timing relations.
  assumes the top module's pins are synced inside about five clocks.
*/
`timescale 1ns/1ps
module serial_uart_data_port_sva (
  input wire logic clk,
  input wire logic reset,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic dout,
  input wire logic dout_oe,
  input wire logic irq_n,
  input wire logic tx,
  input wire logic rts_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence sclk_rise;
    $rose(sclk) && !cs_n;
  endsequence
  sequence dout_hold;
    ##1 $stable(dout) [*5];
  endsequence

  oe_on_a: assert property (
    $fell(cs_n) |-> ##[1:6] dout_oe) else $error("dout_oe late on");
  oe_off_a: assert property (
    $rose(cs_n) |-> ##[1:6] !dout_oe) else $error("dout_oe late off");
  oe_idle_a: assert property (
    cs_n [*8] |-> !dout_oe) else $error("dout_oe on while idle");
  reset_out_a: assert property (
    $fell(reset) |-> irq_n && tx && rts_n && !dout_oe)
    else $error("outputs not at idle after reset");
  shift_hold_a: assert property (
    sclk_rise |-> dout_hold) else $error("dout moved near sclk rise");
  start_len_a: assert property (
    $fell(tx) && cs_n |-> ##1 !tx [*8]) else $error("start bit short");
  rts_cause_a: assert property (
    $changed(rts_n) |-> !cs_n || !$past(cs_n, 8))
    else $error("rts_n moved without access");
  irq_release_a: assert property (
    $rose(irq_n) |-> !cs_n || !$past(cs_n, 8))
    else $error("irq_n released without access");
endmodule

// >>> test/serial_uart_data_port_test.sv
/*
  testbench for the serial-port uart: host model on the port,
  bench drives rx and cts_n and checks every tx frame.
  assumes the package, design, checker and host model compiled first.
*/
`timescale 1ns/1ps
module serial_uart_data_port_test;
  import uart_pkg::*;
  typedef struct {
    logic [11:0] bits;
    int          len;
    int          div;
  } frm_t;
  localparam int LIMIT = 90000;
  logic        clk, reset, osc_input, rx, cts_n;
  logic        sclk, cs_n, din, dout, dout_oe;
  logic        irq_n, tx, rts_n, host_done;
  logic [15:0] host_rsp;
  logic [15:0] rsp_q[$];
  frm_t        frm_q[$], bad;
  logic        ws = 1'h0, par = 1'h0, stp = 1'h0;
  int          div = 1, n_fail = 0, compares = 0, cycles = 0, k;
  logic [7:0]  b[9];

  serial_uart_data_port u_serial_uart_data_port (
    .clk(clk), .reset(reset), .osc_input(osc_input), .sclk(sclk),
    .cs_n(cs_n), .din(din), .dout(dout), .dout_oe(dout_oe),
    .irq_n(irq_n), .rx(rx), .tx(tx), .cts_n(cts_n), .rts_n(rts_n));
  spi_host_model u_spi_host_model (
    .clk(clk), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout),
    .dout_oe(dout_oe), .rsp(host_rsp), .done(host_done));

  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  initial begin
    osc_input = 1'h0;
    #7;
    forever #40 osc_input = ~osc_input;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_fail++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic chk_rsp(input logic [15:0] e, input logic [15:0] g);
    cmp(e, g);
  endtask
  task automatic chk_frm(input logic [12:0] e, input logic [12:0] g);
    cmp({3'h0, e}, {3'h0, g});
  endtask
  task automatic chk_pin(input logic e, input logic g);
    cmp({15'h0000, e}, {15'h0000, g});
  endtask

  // data lsb first, then parity and stop bits
  function automatic frm_t frame(input logic [7:0] d, input logic pt);
    frm_t f;
    f.bits = 12'hfff;
    f.len = ws ? 7 : 8;
    f.bits[7:0] = ws ? {1'h1, d[6:0]} : d;
    if (par)
      f.bits[f.len] = pt;
    f.len = f.len + 1 + int'(par) + int'(stp);
    f.div = div;
    return f;
  endfunction
  task automatic put_rx(input frm_t f);
    int i;
    for (i = 0; i <= f.len; i++) begin
      @(posedge clk) #2 rx = (i == 0) ? 1'h0 : f.bits[i-1];
      repeat (64 * div - 1) @(posedge clk);
    end
    @(posedge clk) #2 rx = 1'h1;
    repeat (64 * div) @(posedge clk);
  endtask
  task automatic xfer(input logic [15:0] cmd, input logic [15:0] e);
    rsp_q.push_back(e);
    u_spi_host_model.xfer(cmd);
  endtask
  task automatic cfg(input logic [13:0] c);
    ws = c[4];
    par = c[5];
    stp = c[6];
    div = (c[3] ? 3 : 1) << c[2:0];
    xfer({2'h3, c}, 16'h4000);
    xfer(16'h4000, {2'h1, c});
  endtask
  task automatic wdat(input logic [7:0] d, input logic pt, inh, r, t);
    if (!inh)
      frm_q.push_back(frame(d, pt));
    xfer({5'h10, inh, r, pt, d}, {1'h0, t, 4'h0, ~cts_n, 9'h000});
    chk_pin(!r, rts_n);
  endtask
  task automatic rdat(input logic r, pt, input logic [7:0] d);
    xfer(16'h0000, {r, 1'h1, 4'h0, ~cts_n, pt, d});
  endtask

  always @(posedge host_done)
    chk_rsp(rsp_q.pop_front(), host_rsp);
  always begin : tx_watch
    frm_t        f;
    logic [12:0] got;
    int          i;
    @(negedge tx);
    f = frm_q.pop_front();
    got = 13'h1fff;
    repeat (32 * f.div) @(negedge clk);
    for (i = 0; i <= f.len; i++) begin
      if (i > 0)
        repeat (64 * f.div) @(negedge clk);
      got[i] = tx;
    end
    chk_frm({f.bits, 1'h0}, got);
  end

  initial begin : main
    k = $urandom(7526);
    reset = 1'h1;
    rx = 1'h1;
    cts_n = 1'($urandom);
    repeat (20) @(posedge clk);
    #2 reset = 1'h0;
    xfer(16'h4000, 16'h4000);
    cfg(14'h0460);
    // third write sets send_inhibit, so it only moves rts; the buffer is still full
    for (k = 0; k < 3; k++)
      wdat(8'($urandom), 1'($urandom), k == 2, k[0], k < 2);
    repeat (3 * 12 * 64) @(posedge clk);
    b[0] = 8'($urandom);
    put_rx(frame(b[0], 1'h1));
    chk_pin(1'h0, irq_n);
    rdat(1'h1, 1'h1, b[0]);
    repeat (10) @(posedge clk);
    chk_pin(1'h1, irq_n);
    wdat(8'h00, 1'h0, 1'h1, 1'h1, 1'h1);
    wdat(8'h00, 1'h0, 1'h1, 1'h0, 1'h1);
    $display("test format done");
    cts_n = ~cts_n;
    cfg(14'h0400);
    // stop bit sent low: flag up, nothing queued
    bad = frame(8'h00, 1'h0);
    bad.bits[8] = 1'h0;
    put_rx(bad);
    xfer(16'h0000, {6'h11, ~cts_n, 9'h000});
    for (k = 0; k < 9; k++) begin
      b[k] = 8'($urandom);
      put_rx(frame(b[k], 1'h0));
    end
    chk_pin(1'h0, irq_n);
    for (k = 0; k < 9; k++)
      rdat(k < 8, 1'h0, k < 8 ? b[k] : 8'h00);
    $display("test fifo done");
    cfg(14'h0410);
    b[0] = 8'($urandom) | 8'h80;
    wdat(b[0], 1'h0, 1'h0, 1'h0, 1'h1);
    put_rx(frame(b[0], 1'h0));
    rdat(1'h1, 1'h0, b[0] & 8'h7f);
    $display("test short word done");
    for (k = 1; k < 10; k = (k == 3) ? 8 : k + 1) begin
      cfg(14'(k));
      wdat(8'h55, 1'h0, 1'h0, 1'h0, 1'h1);
      repeat (11 * 64 * div) @(posedge clk);
    end
    $display("test rates done");
    finish_test();
  end
endmodule

bind serial_uart_data_port serial_uart_data_port_sva u_sva (
  .clk(clk), .reset(reset), .sclk(sclk), .cs_n(cs_n), .dout(dout),
  .dout_oe(dout_oe), .irq_n(irq_n), .tx(tx), .rts_n(rts_n));

// >>> test/spi_host_model.sv
/*
  host model for the serial port: one 16-bit word per call.
  assumes clk at 50 MHz; sclk half period is ten clocks.
*/
`timescale 1ns/1ps
module spi_host_model (
  input  wire logic        clk,
  output logic             cs_n,
  output logic             sclk,
  output logic             din,
  input  wire logic        dout,
  input  wire logic        dout_oe,
  output logic [15:0]      rsp,
  output logic             done
);
  localparam int HALF = 10;
  initial begin
    cs_n = 1'h1;
    sclk = 1'h0;
    din = 1'h0;
    rsp = 16'h0000;
    done = 1'h0;
  end
  task automatic xfer(input logic [15:0] cmd);
    int i;
    repeat (HALF) @(posedge clk);
    #2 cs_n = 1'h0;
    for (i = 15; i >= 0; i--) begin
      din = cmd[i];
      repeat (HALF) @(posedge clk);
      #2 sclk = 1'h1;
      rsp[i] = dout_oe ? dout : 1'bx;
      repeat (HALF) @(posedge clk);
      #2 sclk = 1'h0;
    end
    repeat (HALF) @(posedge clk);
    #2 cs_n = 1'h1;
    // released line shows the inverse
    din = ~din;
    done = 1'h1;
    @(posedge clk);
    #2 done = 1'h0;
  endtask
endmodule
